//--- ccc_consts.svh
// constants of the core and cache clock configuration block
`ifndef CCC_CONSTS_SVH
`define CCC_CONSTS_SVH

// register byte offsets
`define CCC_CTRL_OFS      8'h00
`define CCC_STATUS_OFS    8'h04

// control register field positions
`define CCC_CTRL_EN_BIT   0
`define CCC_CTRL_DIV_LO   4
`define CCC_CTRL_DIV_HI   7

// control register reset values
`define CCC_CTRL_EN_RST   1'b0
`define CCC_CTRL_DIV_RST  4'h0

// status register field positions
`define CCC_STAT_MODE_LO  0
`define CCC_STAT_MODE_HI  1
`define CCC_STAT_PLL_BIT  2
`define CCC_STAT_RUN_BIT  3
`define CCC_STAT_DIV_LO   4
`define CCC_STAT_DIV_HI   7
`define CCC_STAT_STRAP_LO 8
`define CCC_STAT_STRAP_HI 12

// ratio strap codes with special meaning
`define CCC_STRAP_OFF     5'h1E
`define CCC_STRAP_BYPASS  5'h06

// divisor codes: code n gives a divisor of (n + 4) / 2
`define CCC_DIV_MAX_CODE  4'hC
`define CCC_DIV_HALF_BASE 5'h04
`define CCC_ACC_STEP      5'h02

// bus answers
`define CCC_RESP_OKAY     2'h0
`define CCC_RESP_DECERR   2'h3

`endif

//--- ccc_pkg.sv
// types of the core and cache clock configuration block
package ccc_pkg;

  // clocking mode chosen by the ratio strap
  typedef enum logic [1:0] {
    CCC_MODE_PLL    = 2'b00,
    CCC_MODE_BYPASS = 2'b01,
    CCC_MODE_OFF    = 2'b10
  } ccc_mode_type;

  // setting handed to the cache clock divider
  typedef struct packed {
    logic       en;
    logic [3:0] code;
  } ccc_div_cfg_type;

  // state of the cache clock divider
  typedef struct packed {
    logic [4:0] acc;
    logic       level;
    logic [3:0] code;
    logic       run;
  } ccc_div_state_type;

  // state of the top block
  typedef struct packed {
    logic [4:0]   strap_s1;
    logic [4:0]   strap_s2;
    logic         ref_s1;
    logic         ref_s2;
    logic         ref_s3;
    logic         qual_s1;
    logic         qual_s2;
    ccc_mode_type mode;
    logic         core_tick;
    logic         bus_tick;
    logic         ctrl_en;
    logic [3:0]   ctrl_div;
    logic         aw_got;
    logic [7:0]   awaddr;
    logic         w_got;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } ccc_state_type;

endpackage

//--- ccc_cache_div.sv
// cache sram clock divider, half-step divisors from 2 to 8
`timescale 1ns/100ps
`include "ccc_consts.svh"

module ccc_cache_div (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     srst,
  // core clock qualifier and setting
  input  wire logic                     core_tick,
  input  wire ccc_pkg::ccc_div_cfg_type cfg,
  // cache clock and applied state
  output logic                          cache_clk,
  output logic [3:0]                    applied_code,
  output logic                          running
);

  ccc_pkg::ccc_div_state_type st_r;
  ccc_pkg::ccc_div_state_type st_nxt;
  logic [4:0]                 half_n;
  logic [4:0]                 acc_add;

  // half periods of the core clock in one cache period
  assign half_n  = `CCC_DIV_HALF_BASE + {1'b0, st_r.code};
  assign acc_add = st_r.acc + `CCC_ACC_STEP;

  // fractional divide: accumulate two half units per core cycle
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.run = cfg.en;
    if (!cfg.en)
    begin
      st_nxt.acc   = 5'h00;
      st_nxt.level = 1'b0;
      // reserved codes keep the old divisor
      if (cfg.code <= `CCC_DIV_MAX_CODE)
        st_nxt.code = cfg.code;
    end
    else if (core_tick)
    begin
      if (acc_add >= half_n)
        st_nxt.acc = acc_add - half_n;
      else
        st_nxt.acc = acc_add;
      // high in first half of each period
      st_nxt.level = ({st_nxt.acc, 1'b0} < {1'b0, half_n});
    end
  end

  // single state register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r.acc   <= 5'h00;
      st_r.level <= 1'b0;
      st_r.code  <= `CCC_CTRL_DIV_RST;
      st_r.run   <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  assign cache_clk    = st_r.level;
  assign applied_code = st_r.code;
  assign running      = st_r.run;

  div_stable_a: assert property (@(posedge clk) disable iff (srst)
    $changed(st_r.code) |-> $past(!cfg.en) && !cache_clk)
    else $error("divisor changed while cache clock enabled");

  // applied code always one of thirteen
  div_code_legal_a: assert property (@(posedge clk) disable iff (srst)
    st_r.code <= `CCC_DIV_MAX_CODE)
    else $error("applied divisor code out of range");

  // cache rising edges follow core cycles only
  cache_edge_core_a: assert property (@(posedge clk) disable iff (srst)
    $rose(cache_clk) |-> $past(core_tick))
    else $error("cache clock rose without a core cycle");

  // divide by two toggles every core cycle
  div_two_a: assert property (@(posedge clk) disable iff (srst)
    (st_r.run && st_r.code == 4'h0 && core_tick && cfg.en)
      ##1 (core_tick && cfg.en) |=> $changed(cache_clk))
    else $error("divide by two did not toggle");

endmodule // ccc_cache_div

//--- ccc_clock_config.sv
// core and cache clock configuration with axi4-lite registers
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "ccc_consts.svh"

module ccc_clock_config (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // pins from the system clock generator
  input  wire logic [4:0]  ratio_strap,
  input  wire logic        bus_reference_clock,
  input  wire logic        external_bus_qualifier,
  // clocking outputs
  output logic             pll_enable,
  output logic             core_clk_en,
  output logic             bus_clk_en,
  output logic             cache_clk,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  ccc_pkg::ccc_state_type   st_r;
  ccc_pkg::ccc_state_type   st_nxt;
  ccc_pkg::ccc_div_cfg_type div_cfg;
  logic [3:0]               applied_code;
  logic                     div_running;
  logic                     ref_rise;
  logic                     wr_fire;
  logic                     rd_fire;

  // strap decode, used only by the mode logic
  function automatic ccc_pkg::ccc_mode_type strap_mode(input logic [4:0] s);
    if (s == `CCC_STRAP_OFF)
      strap_mode = ccc_pkg::CCC_MODE_OFF;
    else if (s == `CCC_STRAP_BYPASS)
      strap_mode = ccc_pkg::CCC_MODE_BYPASS;
    else
      strap_mode = ccc_pkg::CCC_MODE_PLL;
  endfunction

  // word address match, shared by write and read decode
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] o);
    addr_is = (a[7:2] == o[7:2]);
  endfunction

  // ref_s2 against ref_s3 only; ref_s1 feeds nothing but ref_s2
  assign ref_rise = st_r.ref_s2 && !st_r.ref_s3;

  // handshake outputs straight from state
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign wr_fire       = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  // next state of the whole block
  always_comb
  begin
    st_nxt          = st_r;
    // pins cross two flip-flops before use
    st_nxt.strap_s1 = ratio_strap;
    st_nxt.strap_s2 = st_r.strap_s1;
    st_nxt.ref_s1   = bus_reference_clock;
    st_nxt.ref_s2   = st_r.ref_s1;
    st_nxt.ref_s3   = st_r.ref_s2;
    st_nxt.qual_s1  = external_bus_qualifier;
    st_nxt.qual_s2  = st_r.qual_s1;
    // strap read every cycle; it is assumed static while running
    st_nxt.mode     = strap_mode(st_r.strap_s2);

    // clock qualifiers per mode
    unique case (st_r.mode)
      ccc_pkg::CCC_MODE_PLL:
      begin
        // multiplied clock modelled as every cycle
        st_nxt.core_tick = 1'b1;
        st_nxt.bus_tick  = ref_rise;
      end
      ccc_pkg::CCC_MODE_BYPASS:
      begin
        st_nxt.core_tick = ref_rise;
        st_nxt.bus_tick  = ref_rise && st_r.qual_s2;
      end
      ccc_pkg::CCC_MODE_OFF:
      begin
        st_nxt.core_tick = 1'b0;
        st_nxt.bus_tick  = 1'b0;
      end
      default:
      begin
        st_nxt.core_tick = 1'b0;
        st_nxt.bus_tick  = 1'b0;
      end
    endcase

    // write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end

    // register write once both halves are held
    if (wr_fire)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = `CCC_RESP_OKAY;
      if (addr_is(st_r.awaddr, `CCC_CTRL_OFS))
      begin
        if (st_r.wstrb[0])
        begin
          st_nxt.ctrl_en  = st_r.wdata[`CCC_CTRL_EN_BIT];
          st_nxt.ctrl_div = st_r.wdata[`CCC_CTRL_DIV_HI:`CCC_CTRL_DIV_LO];
        end
      end
      else if (!addr_is(st_r.awaddr, `CCC_STATUS_OFS))
        st_nxt.bresp = `CCC_RESP_DECERR;
    end
    else if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;

    // register read, answered the next cycle
    if (rd_fire)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = `CCC_RESP_OKAY;
      st_nxt.rdata  = 32'h0000_0000;
      if (addr_is(s_axi_araddr, `CCC_CTRL_OFS))
      begin
        st_nxt.rdata[`CCC_CTRL_EN_BIT] = st_r.ctrl_en;
        st_nxt.rdata[`CCC_CTRL_DIV_HI:`CCC_CTRL_DIV_LO] = st_r.ctrl_div;
      end
      else if (addr_is(s_axi_araddr, `CCC_STATUS_OFS))
      begin
        st_nxt.rdata[`CCC_STAT_MODE_HI:`CCC_STAT_MODE_LO] = st_r.mode;
        st_nxt.rdata[`CCC_STAT_PLL_BIT] = pll_enable;
        st_nxt.rdata[`CCC_STAT_RUN_BIT] = div_running;
        st_nxt.rdata[`CCC_STAT_DIV_HI:`CCC_STAT_DIV_LO] = applied_code;
        st_nxt.rdata[`CCC_STAT_STRAP_HI:`CCC_STAT_STRAP_LO] = st_r.strap_s2;
      end
      else
        st_nxt.rresp = `CCC_RESP_DECERR;
    end
    else if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
  end

  // single state register; off mode until the strap is seen
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r           <= '0;
      st_r.mode      <= ccc_pkg::CCC_MODE_OFF;
      // strap pipe holds the off code, so no pll cycles slip out on release
      st_r.strap_s1  <= `CCC_STRAP_OFF;
      st_r.strap_s2  <= `CCC_STRAP_OFF;
      st_r.ctrl_en   <= `CCC_CTRL_EN_RST;
      st_r.ctrl_div  <= `CCC_CTRL_DIV_RST;
    end
    else
      st_r <= st_nxt;
  end

  // pll runs only in multiplied mode
  assign pll_enable   = (st_r.mode == ccc_pkg::CCC_MODE_PLL);
  assign core_clk_en  = st_r.core_tick;
  assign bus_clk_en   = st_r.bus_tick;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp  = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata  = st_r.rdata;
  assign s_axi_rresp  = st_r.rresp;

  // cache clock divided from core cycles
  assign div_cfg.en   = st_r.ctrl_en;
  assign div_cfg.code = st_r.ctrl_div;

  ccc_cache_div u_cache_div (
    .clk          (clk),
    .srst         (srst),
    .core_tick    (st_r.core_tick),
    .cfg          (div_cfg),
    .cache_clk    (cache_clk),
    .applied_code (applied_code),
    .running      (div_running)
  );

  // steps of a bypass core cycle
  sequence bypass_ref_edge_s;
    st_r.mode == ccc_pkg::CCC_MODE_BYPASS && ref_rise;
  endsequence

  sequence core_tick_s;
    core_clk_en;
  endsequence

  off_no_clock_a: assert property (@(posedge clk) disable iff (srst)
    st_r.mode == ccc_pkg::CCC_MODE_OFF |=> !core_clk_en && !bus_clk_en)
    else $error("clocking seen in pll off mode");

  // off strap reaches off mode in three cycles
  off_strap_a: assert property (@(posedge clk) disable iff (srst)
    (ratio_strap == `CCC_STRAP_OFF) [*3] |=> !pll_enable)
    else $error("pll still enabled after off strap");

  bypass_core_a: assert property (@(posedge clk) disable iff (srst)
    bypass_ref_edge_s |=> core_tick_s)
    else $error("bypass core cycle missing after reference edge");

  // bypass keeps pll off and no free core cycles
  bypass_pll_a: assert property (@(posedge clk) disable iff (srst)
    st_r.mode == ccc_pkg::CCC_MODE_BYPASS && !ref_rise
      |=> !pll_enable && !core_clk_en)
    else $error("bypass core cycle without reference edge");

  // bypass bus cycles only on qualified core cycles
  bus_on_core_a: assert property (@(posedge clk) disable iff (srst)
    st_r.mode == ccc_pkg::CCC_MODE_BYPASS ##1
      (bus_clk_en && st_r.mode == ccc_pkg::CCC_MODE_BYPASS)
      |-> core_clk_en && $past(st_r.qual_s2))
    else $error("bypass bus cycle not on qualified core cycle");

  ctrl_write_a: assert property (@(posedge clk) disable iff (srst)
    wr_fire && addr_is(st_r.awaddr, `CCC_CTRL_OFS) && st_r.wstrb[0]
      |=> s_axi_bvalid && st_r.ctrl_div ==
        $past(st_r.wdata[`CCC_CTRL_DIV_HI:`CCC_CTRL_DIV_LO]))
    else $error("control write did not land");

  // enable drop stops cache clock one cycle later
  cache_stop_a: assert property (@(posedge clk) disable iff (srst)
    !st_r.ctrl_en ##1 !st_r.ctrl_en |-> !cache_clk)
    else $error("cache clock high while disabled");

  // write answer one cycle after both halves
  write_resp_a: assert property (@(posedge clk) disable iff (srst)
    wr_fire |=> s_axi_bvalid ##0 !s_axi_awready ##0 !s_axi_wready)
    else $error("write response late");

endmodule // ccc_clock_config

//--- ccc_clkgen_model.sv
// model of the system clock generator driving strap, reference, qualifier
`timescale 1ns/100ps

module ccc_clkgen_model (
  // clock and strap chosen by the bench
  input  wire logic       clk,
  input  wire logic [4:0] strap_sel,
  // pins toward the device
  output logic [4:0]      ratio_strap,
  output logic            bus_reference_clock,
  output logic            external_bus_qualifier
);
  logic [2:0] cnt_r  = 3'h0;
  logic       qual_r = 1'b0;

  // defined codes only, changed by the bench under reset
  assign ratio_strap = strap_sel;
  // reference is eight clk cycles long, slow enough to be sampled
  assign bus_reference_clock    = cnt_r[2];
  assign external_bus_qualifier = qual_r;

  // qualifier at half reference rate, flips on reference fall
  always @(posedge clk)
  begin
    cnt_r <= cnt_r + 3'h1;
    if (cnt_r == 3'h7)
      qual_r <= ~qual_r;
  end
endmodule // ccc_clkgen_model

//--- ccc_clock_config_tb.sv
// self-checking bench of the core and cache clock configuration block
`timescale 1ns/100ps
`include "ccc_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module ccc_clock_config_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  strap_sel = `CCC_STRAP_OFF;
  logic [4:0]  ratio_strap;
  logic        ref_clk, qual, pll_enable, core_clk_en, bus_clk_en, cache_clk;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, eb;
  logic [31:0] rdata;
  logic [33:0] er;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  logic [7:0]  lfsr_r = 8'h41;
  logic [4:0]  strap_m;
  logic        cache_d = 1'b0;
  int          n_errors = 0, compares = 0, cycles = 0;
  int          n_core = 0, n_bus = 0, n_cache = 0;

  ccc_clkgen_model i_ccc_clkgen_model (.clk(clk), .strap_sel(strap_sel),
    .ratio_strap(ratio_strap), .bus_reference_clock(ref_clk),
    .external_bus_qualifier(qual));

  ccc_clock_config i_ccc_clock_config (.clk(clk), .srst(srst),
    .ratio_strap(ratio_strap), .bus_reference_clock(ref_clk),
    .external_bus_qualifier(qual), .pll_enable(pll_enable),
    .core_clk_en(core_clk_en), .bus_clk_en(bus_clk_en),
    .cache_clk(cache_clk), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp));

  // 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] lfsr_nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // expected status word with an okay answer
  function automatic logic [33:0] st(input logic [1:0] m,
    input logic p, input logic r, input logic [3:0] c);
    return {`CCC_RESP_OKAY, 19'h0, strap_sel, c, r, p, m};
  endfunction

  task automatic conclude();
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // reset held six cycles; strap only moves while reset is high
  task automatic do_reset(input logic [4:0] s);
    srst      <= 1'b1;
    strap_sel <= s;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  // one write; address and data offered together, each freed when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    exp_b.push_back(r);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  // one read; the monitor compares the answer
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // pulses seen over a whole number of reference periods
  task automatic count(input int n, input int ec, input int eb,
    input int ek, input logic ep);
    int c0, b0, k0;
    // read counters off the edge so the monitor update never races
    @(negedge clk);
    c0 = n_core;
    b0 = n_bus;
    k0 = n_cache;
    repeat (n) @(negedge clk);
    `CHK(n_core - c0, ec)
    `CHK(n_bus - b0, eb)
    `CHK(n_cache - k0, ek)
    `CHK(pll_enable, ep)
    @(posedge clk);
  endtask

  // output monitor: pulse counts, answers against oldest notes, timeout
  always @(posedge clk)
  begin
    cycles++;
    cache_d <= cache_clk;
    if (core_clk_en === 1'b1)
      n_core++;
    if (bus_clk_en === 1'b1)
      n_bus++;
    if (cache_clk === 1'b1 && cache_d === 1'b0)
      n_cache++;
    if (rvalid === 1'b1 && rready === 1'b1)
    begin
      er = exp_r.pop_front();
      `CHK({rresp, rdata}, er)
    end
    if (bvalid === 1'b1 && bready === 1'b1)
    begin
      eb = exp_b.pop_front();
      `CHK(bresp, eb)
    end
    if (cycles == 20000)
    begin
      n_errors++;
      conclude();
    end
  end

  // main sequence
  initial
  begin
    do_reset(`CCC_STRAP_OFF);
    rd(`CCC_CTRL_OFS, 34'h0);
    rd(8'h08, {`CCC_RESP_DECERR, 32'h0});
    wr(8'h08, 32'hFFFF_FFFF, `CCC_RESP_DECERR);
    wr(`CCC_STATUS_OFS, 32'hFFFF_FFFF, `CCC_RESP_OKAY);
    rd(`CCC_STATUS_OFS, st(ccc_pkg::CCC_MODE_OFF, 1'b0, 1'b0, 4'h0));
    wr(`CCC_CTRL_OFS, 32'hAB00_0030, `CCC_RESP_OKAY);
    wr(`CCC_CTRL_OFS, 32'h5500_0031, `CCC_RESP_OKAY);
    rd(`CCC_CTRL_OFS, 34'h31);
    // no clocking at all when the pll is off
    count(80, 0, 0, 0, 1'b0);
    wr(`CCC_CTRL_OFS, 32'h0, `CCC_RESP_OKAY);
    // bypass: core per reference rise, bus at half that
    do_reset(`CCC_STRAP_BYPASS);
    count(80, 10, 5, 0, 1'b0);
    rd(`CCC_STATUS_OFS, st(ccc_pkg::CCC_MODE_BYPASS, 1'b0, 1'b0, 4'h0));
    lfsr_r  = lfsr_nxt(lfsr_r);
    strap_m = lfsr_r[4:0];
    if (strap_m == `CCC_STRAP_OFF || strap_m == `CCC_STRAP_BYPASS)
      strap_m = strap_m ^ 5'h01;
    do_reset(strap_m);
    count(80, 80, 10, 0, 1'b1);
    // every divisor code; two cache periods per n+4 cycles
    for (int n = 0; n <= 12; n++)
    begin
      lfsr_r = lfsr_nxt(lfsr_r);
      wr(`CCC_CTRL_OFS, {lfsr_r, 16'h0, n[3:0], 4'h0}, `CCC_RESP_OKAY);
      rd(`CCC_STATUS_OFS, st(ccc_pkg::CCC_MODE_PLL, 1'b1, 1'b0, n[3:0]));
      wr(`CCC_CTRL_OFS, {24'h0, n[3:0], 4'h1}, `CCC_RESP_OKAY);
      count((n + 4) * 8, (n + 4) * 8, n + 4, 16, 1'b1);
    end
    // new divisor waits until the cache clock is stopped
    wr(`CCC_CTRL_OFS, 32'h21, `CCC_RESP_OKAY);
    rd(`CCC_CTRL_OFS, 34'h21);
    rd(`CCC_STATUS_OFS, st(ccc_pkg::CCC_MODE_PLL, 1'b1, 1'b1, 4'hC));
    wr(`CCC_CTRL_OFS, 32'h20, `CCC_RESP_OKAY);
    rd(`CCC_STATUS_OFS, st(ccc_pkg::CCC_MODE_PLL, 1'b1, 1'b0, 4'h2));
    count(64, 64, 8, 0, 1'b1);
    // reserved code leaves the applied divisor alone
    wr(`CCC_CTRL_OFS, 32'hD0, `CCC_RESP_OKAY);
    rd(`CCC_STATUS_OFS, st(ccc_pkg::CCC_MODE_PLL, 1'b1, 1'b0, 4'h2));
    // write without byte 0 leaves the control word alone
    wstrb <= 4'hE;
    wr(`CCC_CTRL_OFS, 32'h31, `CCC_RESP_OKAY);
    wstrb <= 4'hF;
    rd(`CCC_CTRL_OFS, 34'hD0);
    conclude();
  end
endmodule // ccc_clock_config_tb
